// [uart_data_buffer_consts.svh]
// constant values for the serial data buffer and baud timer
`ifndef UART_DATA_BUFFER_CONSTS_SVH
`define UART_DATA_BUFFER_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SERIAL_DATA_BUFFER_ADDR  8'h99
`define SERIAL_DATA_BUFFER_RESET 8'h00
// ----------------------------------------------------------------
// timer 1 prescale codes and divide factors
// ----------------------------------------------------------------
`define PRESCALE_SYS_DIV12 2'b00
`define PRESCALE_SYS_DIV4  2'b01
`define PRESCALE_SYS_DIV48 2'b10
`define PRESCALE_EXT_DIV8  2'b11
`define DIV12_LAST         6'h0b
`define DIV4_LAST          6'h03
`define DIV48_LAST         6'h2f
`define EXT_DIV8_LAST      6'h07
`define TIMER1_TOP         8'hff
// ----------------------------------------------------------------
// frame layout and receive fifo depth
// ----------------------------------------------------------------
`define DATA_BITS_LAST     3'h7
`define FIFO_DEPTH_DEFAULT 4
`endif

// [uart_data_buffer_pkg.sv]
// types shared by the serial data buffer design
package uart_data_buffer_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;
endpackage

// [uart_data_buffer_baud_setup.sv]
// serial port data buffer, baud timer and receive fifo
// How it works
// [R1] one address, separate transmit and receive storage
// [R2] written byte held until fully shifted out
// [R3] buffer write alone starts the frame
// [R4] reads return receive latch, never transmit byte
// [R5] buffer is eight bits, read and write
// [R6] prescale code picks system_clock/12, /4, /48, ext/8
// [R7] clock select one runs timer undivided
// [R8] software picks ext/8 and reload for 9600
// [R9] baud is half the timer overflow rate
// [R10] latch loads only with flag clear, check passed
// [R11] overrun keeps first byte, queues FIFO_DEPTH more frames, drops the rest
// [R12] reset clears storage, transmitter idle
`timescale 1ns/1ns
`default_nettype none
`include "uart_data_buffer_consts.svh"

// ----------------------------------------------------------------
// small fifo between the receiver and the receive latch
// ----------------------------------------------------------------
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr_reg;        // next slot to fill
  logic [AW-1:0]    rd_ptr_reg;        // oldest word
  logic [AW:0]      count_reg;         // words held
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // compare at counter width; a pointer-wide depth would wrap to zero
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and fill level update, wrapping at the depth
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
    end
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  // pointers are reset, data words need no reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------
// top: data buffer, baud timer, transmitter, receiver
// ----------------------------------------------------------------
module uart_data_buffer_baud_setup #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] sfr_addr_i,               // special-function address
  input  wire logic       sfr_wr_i,                 // write strobe
  input  wire logic       sfr_rd_i,                 // read strobe
  input  wire logic [7:0] sfr_wdata_i,              // write data
  output logic      [7:0] sfr_rdata_o,              // read data, one cycle later
  input  wire logic [1:0] timer_prescale_code_i,
  input  wire logic       timer1_clock_select_i,
  input  wire logic [7:0] timer1_reload_high_i,
  input  wire logic       external_osc_clock_i,     // asynchronous oscillator pin
  input  wire logic       receive_enable_i,
  input  wire logic       multiproc_check_enable_i,
  input  wire logic       receive_flag_clear_i,     // software clears the flag
  output logic            receive_done_flag_o,
  output logic            transmit_busy_o,
  output logic            tx_o,
  input  wire logic       rx_i
);
  import uart_data_buffer_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rx_sync_reg;    // bit 0 only feeds bit 1
  logic [1:0] ext_sync_reg;   // bit 0 only feeds bit 1
  logic       ext_last_reg;   // previous synced level, for edges
  logic       rx_last_reg;    // previous synced line level
  logic       rx_s;
  logic       rx_fall;        // line went from high to low
  logic       ext_rise;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sync_reg  <= 2'b11;
      ext_sync_reg <= 2'b00;
      ext_last_reg <= 1'b0;
      rx_last_reg  <= 1'b1;   // idle level, so no false start after reset
    end else begin
      rx_sync_reg  <= {rx_sync_reg[0], rx_i};
      ext_sync_reg <= {ext_sync_reg[0], external_osc_clock_i};
      ext_last_reg <= ext_sync_reg[1];
      rx_last_reg  <= rx_sync_reg[1];
    end
  end
  assign rx_s     = rx_sync_reg[1];
  assign rx_fall  = rx_last_reg & ~rx_s;
  assign ext_rise = ext_sync_reg[1] & ~ext_last_reg;

  // ----------------------------------------------------------------
  // prescaler and timer 1 in auto-reload
  // ----------------------------------------------------------------
  logic [5:0] presc_reg;      // prescale counter
  logic [7:0] t1_reg;         // timer 1 count
  logic       half_reg;       // divides overflows by two
  logic [5:0] presc_next;
  logic [7:0] t1_next;
  logic       half_next;
  logic [5:0] presc_last;
  logic       presc_step;
  logic       t1_tick;
  logic       t1_ovf;
  logic       baud_tick;

  // prescale selection; the external source counts synced rising edges
  always_comb begin
    unique case (timer_prescale_code_i)                     // see [R6]
      `PRESCALE_SYS_DIV12: presc_last = `DIV12_LAST;
      `PRESCALE_SYS_DIV4:  presc_last = `DIV4_LAST;
      `PRESCALE_SYS_DIV48: presc_last = `DIV48_LAST;
      `PRESCALE_EXT_DIV8:  presc_last = `EXT_DIV8_LAST;
    endcase
    presc_step = (timer_prescale_code_i == `PRESCALE_EXT_DIV8) ? ext_rise : 1'b1;
    presc_next = presc_reg;
    if (presc_step) begin
      presc_next = (presc_reg >= presc_last) ? 6'h00 : presc_reg + 6'h01;
    end
    // select one bypasses the prescaler entirely
    t1_tick   = timer1_clock_select_i ? 1'b1                // see [R7]
                                      : (presc_step && presc_reg >= presc_last);
    t1_ovf    = t1_tick && (t1_reg == `TIMER1_TOP);
    t1_next   = t1_reg;
    if (t1_tick) begin
      t1_next = t1_ovf ? timer1_reload_high_i : t1_reg + 8'h01;  // see [R9]
    end
    half_next = t1_ovf ? ~half_reg : half_reg;
    baud_tick = t1_ovf & half_reg;                          // see [R9]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_reg <= 6'h00;
      t1_reg    <= 8'h00;
      half_reg  <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      t1_reg    <= t1_next;
      half_reg  <= half_next;
    end
  end

  // ----------------------------------------------------------------
  // register access and transmitter
  // ----------------------------------------------------------------
  logic       buf_wr;
  tx_state_e  tx_state_reg;
  tx_state_e  tx_state_next;
  logic [7:0] tx_shift_reg;   // byte being sent, kept whole until done
  logic [7:0] tx_shift_next;
  logic [2:0] tx_bit_reg;
  logic [2:0] tx_bit_next;
  logic       tx_line_reg;
  logic       tx_line_next;

  // one address; writes go to the transmit side only
  assign buf_wr = sfr_wr_i && (sfr_addr_i == `SERIAL_DATA_BUFFER_ADDR);  // see [R1]

  // frame: start, eight data bits lsb first, stop, on baud ticks;
  // a write while busy is ignored so the byte in flight stays intact
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_bit_next   = tx_bit_reg;
    tx_line_next  = tx_line_reg;
    unique case (tx_state_reg)
      TX_IDLE: begin
        tx_line_next = 1'b1;
        if (buf_wr) begin
          tx_shift_next = sfr_wdata_i;                      // see [R2] [R5]
          tx_state_next = TX_START;                         // see [R3]
        end
      end
      TX_START: begin
        if (baud_tick) begin
          tx_line_next  = 1'b0;
          tx_bit_next   = 3'h0;
          tx_state_next = TX_DATA;
        end
      end
      TX_DATA: begin
        if (baud_tick) begin
          tx_line_next = tx_shift_reg[tx_bit_reg];          // see [R2]
          tx_bit_next  = tx_bit_reg + 3'h1;
          if (tx_bit_reg == `DATA_BITS_LAST) begin
            tx_state_next = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        // first tick opens the stop bit, the second ends it
        if (baud_tick) begin
          tx_line_next = 1'b1;
          tx_bit_next  = 3'h1;
          if (tx_bit_reg != 3'h0) begin
            tx_state_next = TX_IDLE;    // stop bit has lasted a full bit time
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state_reg <= TX_IDLE;                              // see [R12]
      tx_shift_reg <= `SERIAL_DATA_BUFFER_RESET;            // see [R12]
      tx_bit_reg   <= 3'h0;
      tx_line_reg  <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_bit_reg   <= tx_bit_next;
      tx_line_reg  <= tx_line_next;
    end
  end
  assign tx_o            = tx_line_reg;
  assign transmit_busy_o = (tx_state_reg != TX_IDLE);

  // ----------------------------------------------------------------
  // receiver: samples at overflow ticks, two overflows per bit
  // ----------------------------------------------------------------
  rx_state_e  rx_state_reg;
  rx_state_e  rx_state_next;
  logic [7:0] rx_data_reg;
  logic [7:0] rx_data_next;
  logic [2:0] rx_bit_reg;
  logic [2:0] rx_bit_next;
  logic       rx_phase_reg;   // high on the overflow that lands mid-bit
  logic       rx_phase_next;
  logic       push_valid;

  // first overflow after the falling edge lands within half a bit;
  // resolution is half a bit, a limit of using the raw overflow rate
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_data_next  = rx_data_reg;
    rx_bit_next   = rx_bit_reg;
    rx_phase_next = rx_phase_reg;
    push_valid    = 1'b0;
    unique case (rx_state_reg)
      RX_IDLE: begin
        // an edge, not a level: a low stop bit must not restart a frame
        if (receive_enable_i && rx_fall) begin
          rx_state_next = RX_START;
        end
      end
      RX_START: begin
        if (t1_ovf) begin
          rx_state_next = rx_s ? RX_IDLE : RX_DATA;         // glitch rejected
          rx_bit_next   = 3'h0;
          rx_phase_next = 1'b0;
        end
      end
      RX_DATA: begin
        if (t1_ovf) begin
          rx_phase_next = ~rx_phase_reg;
          if (rx_phase_reg) begin
            rx_data_next = {rx_s, rx_data_reg[7:1]};
            rx_bit_next  = rx_bit_reg + 3'h1;
            if (rx_bit_reg == `DATA_BITS_LAST) begin
              rx_state_next = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (t1_ovf) begin
          rx_phase_next = ~rx_phase_reg;
          if (rx_phase_reg) begin
            // with checking on, a low stop bit keeps the byte out
            push_valid    = !multiproc_check_enable_i || rx_s;  // see [R10]
            rx_state_next = RX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state_reg <= RX_IDLE;
      rx_data_reg  <= 8'h00;
      rx_bit_reg   <= 3'h0;
      rx_phase_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_data_reg  <= rx_data_next;
      rx_bit_reg   <= rx_bit_next;
      rx_phase_reg <= rx_phase_next;
    end
  end

  // ----------------------------------------------------------------
  // fifo, receive latch and read path
  // ----------------------------------------------------------------
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       latch_load;
  logic [7:0] rx_latch_reg;   // what software reads
  logic [7:0] rx_latch_next;
  logic       rx_flag_reg;
  logic       rx_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // a frame arriving with the fifo full is simply not taken
  rx_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (),                                        // see [R11]
    .in_data_i   (rx_data_reg),
    .out_valid_o (fifo_valid),
    .out_ready_i (latch_load),
    .out_data_o  (fifo_data)
  );

  // latch only fills while the flag is clear, so the first byte stays
  always_comb begin
    latch_load    = fifo_valid && !rx_flag_reg;             // see [R10] [R11]
    rx_latch_next = latch_load ? fifo_data : rx_latch_reg;
    rx_flag_next  = rx_flag_reg;
    if (receive_flag_clear_i) begin
      rx_flag_next = 1'b0;
    end
    if (latch_load) begin
      rx_flag_next = 1'b1;      // set beats a same-cycle clear
    end
    rdata_next = 8'h00;
    if (sfr_rd_i && (sfr_addr_i == `SERIAL_DATA_BUFFER_ADDR)) begin
      rdata_next = rx_latch_reg;                            // see [R4] [R1]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_latch_reg <= `SERIAL_DATA_BUFFER_RESET;            // see [R12]
      rx_flag_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      rx_latch_reg <= rx_latch_next;
      rx_flag_reg  <= rx_flag_next;
      rdata_reg    <= rdata_next;
    end
  end
  assign sfr_rdata_o         = rdata_reg;
  assign receive_done_flag_o = rx_flag_reg;
endmodule
`default_nettype wire

// [uart_data_buffer_sva.sv]
// assertion checker for the serial data buffer ports
`timescale 1ns/1ns
`default_nettype none
`include "uart_data_buffer_consts.svh"
module uart_data_buffer_sva (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       receive_flag_clear_i,
  input wire logic       receive_done_flag_o,
  input wire logic       transmit_busy_o,
  input wire logic       tx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // -------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------
  // buffer read while a received byte is held and not released
  sequence s_rd_held;
    sfr_rd_i && sfr_addr_i == `SERIAL_DATA_BUFFER_ADDR
      && receive_done_flag_o && !receive_flag_clear_i;
  endsequence
  property p_rd_other;
    !(sfr_rd_i && sfr_addr_i == `SERIAL_DATA_BUFFER_ADDR) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("read data without buffer read");
  property p_wr_starts;
    sfr_wr_i && sfr_addr_i == `SERIAL_DATA_BUFFER_ADDR && !transmit_busy_o |=> transmit_busy_o;
  endproperty
  a_wr_starts: assert property (p_wr_starts) else $error("write did not start a frame");
  property p_busy_cause;
    $rose(transmit_busy_o) |-> $past(sfr_wr_i) && $past(sfr_addr_i) == 8'h99 && tx_o;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("frame began without a write");
  property p_idle_high;
    !transmit_busy_o |-> tx_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  property p_start_needs_busy;
    $fell(tx_o) |-> transmit_busy_o;
  endproperty
  a_start_needs_busy: assert property (p_start_needs_busy) else $error("start bit when idle");
  property p_stop_before_idle;
    $fell(transmit_busy_o) |-> tx_o && $past(tx_o);
  endproperty
  a_stop_before_idle: assert property (p_stop_before_idle) else $error("frame cut short");
  property p_flag_holds;
    receive_done_flag_o && !receive_flag_clear_i |=> receive_done_flag_o;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped on its own");
  property p_latch_stable;
    s_rd_held ##1 s_rd_held |=> sfr_rdata_o == $past(sfr_rdata_o);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("latch changed while held");
endmodule
bind uart_data_buffer_baud_setup uart_data_buffer_sva chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .receive_flag_clear_i(receive_flag_clear_i),
  .receive_done_flag_o(receive_done_flag_o), .transmit_busy_o(transmit_busy_o), .tx_o(tx_o));
`default_nettype wire

// [uart_far_end.sv]
// far-end serial transceiver model driving and decoding the link
`timescale 1ns/1ns
`default_nettype none
module uart_far_end #(
  parameter int BIT = 32  // clocks per bit
) (
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output var  logic rx_line_o
);
  logic [7:0] got[$];  // bytes decoded from the device
  logic [7:0] sh;      // decode shift register
  initial rx_line_o = 1'b1;  // line idles high
  // send one frame lsb first with a chosen stop level, then one idle bit
  task automatic send_frame(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_o <= f[i];
      repeat (BIT) @(negedge clk_i);
    end
    rx_line_o <= 1'b1;
    repeat (BIT) @(negedge clk_i);  // slack for the device's sample phase
  endtask
  // decode device frames, sampling each bit in its middle
  always begin
    @(negedge tx_line_i);
    repeat (BIT / 2) @(negedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(negedge clk_i);
      if (i < 8) begin
        sh[i] = tx_line_i;
      end
    end
    got.push_back(sh);
  end
endmodule
`default_nettype wire

// [test_uart_data_buffer_baud_setup.sv]
// self-checking testbench for the serial data buffer and baud timer
`timescale 1ns/1ns
`default_nettype none
module test_uart_data_buffer_baud_setup;
  logic       clk    = 1'b0;   // 125 MHz system clock
  logic       nrst   = 1'b0;   // active low reset
  logic       ext    = 1'b0;   // oscillator pin, 25 MHz
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic       wr     = 1'b0;
  logic       rd     = 1'b0;
  logic [1:0] code   = 2'b00;
  logic       sel    = 1'b1;
  logic [7:0] reload = 8'hf0;  // 32 clocks per bit with sel high
  logic       ren    = 1'b1;
  logic       mce    = 1'b0;
  logic       clr    = 1'b0;
  logic [7:0] rdata;
  logic       flag;
  logic       busy;
  logic       tx;
  logic       rx;
  int         n_errors = 0;
  int         n_checks = 0;
  always #4 clk = ~clk;
  // offset so oscillator edges never meet a clock edge
  initial #2 forever #20 ext = ~ext;
  uart_data_buffer_baud_setup dut (
    .clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .timer_prescale_code_i(code),
    .timer1_clock_select_i(sel), .timer1_reload_high_i(reload), .external_osc_clock_i(ext),
    .receive_enable_i(ren), .multiproc_check_enable_i(mce), .receive_flag_clear_i(clr),
    .receive_done_flag_o(flag), .transmit_busy_o(busy), .tx_o(tx), .rx_i(rx));
  uart_far_end #(.BIT(32)) far (.clk_i(clk), .tx_line_i(tx), .rx_line_o(rx));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
  endtask
  // pulse the flag clear, then let the next queued byte settle
  task automatic release_flag;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_reset;
    logic [7:0] v;
    check("flag", 0, flag);
    check("busy", 0, busy);
    check("line", 1, tx);
    sfr_read(8'h99, v);
    check("buffer", 8'h00, v);
    sfr_write(8'h98, 8'h55);
    sfr_read(8'h98, v);
    check("other address", 8'h00, v);
    check("busy", 0, busy);
  endtask
  // start-bit length of an 0xff byte for each clock choice
  task automatic t_baud;
    logic [1:0] cd[5] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b11};
    logic [7:0] rl[5] = '{8'hff, 8'hff, 8'hfe, 8'hff, 8'h5d};
    int len[5] = '{2, 24, 16, 96, 13040};
    int n;
    for (int i = 0; i < 5; i++) begin
      sel = (i == 0);
      code = cd[i];
      reload = rl[i];
      do_reset;
      sfr_write(8'h99, 8'hff);
      for (n = 0; n < 30000 && tx !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 30000 && tx !== 1'b1; n++) @(negedge clk);
      check("bit clocks", len[i][15:0], n[15:0]);
    end
    sel = 1'b1;
    reload = 8'hf0;
    do_reset;
  endtask
  task automatic t_tx;
    logic [7:0] v;
    far.got.delete();
    sfr_write(8'h99, 8'ha5);
    sfr_write(8'h99, 8'h3c);
    sfr_read(8'h99, v);
    check("read while sending", 8'h00, v);
    for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk);
    check("busy", 0, busy);
    sfr_write(8'h99, 8'h3c);
    for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk);
    check("busy", 0, busy);
    repeat (40) @(negedge clk);
    check("frames", 2, 16'(far.got.size()));
    check("first byte", 8'ha5, far.got[0]);
    check("second byte", 8'h3c, far.got[1]);
  endtask
  task automatic t_rx;
    logic [7:0] v;
    far.send_frame(8'h5a, 1'b1);
    sfr_read(8'h99, v);
    check("received", 8'h5a, v);
    for (int i = 0; i < 5; i++) far.send_frame(8'h10 + i[7:0], 1'b1);
    @(negedge clk);
    addr = 8'h99;
    rd = 1'b1;
    @(negedge clk);
    v = rdata;
    @(negedge clk);
    rd = 1'b0;
    check("kept byte", 8'h5a, v);
    check("kept byte", 8'h5a, rdata);
    for (int i = 0; i < 4; i++) begin
      release_flag;
      check("flag", 1, flag);
      sfr_read(8'h99, v);
      check("queued byte", 8'h10 + i[7:0], v);
    end
    release_flag;
    check("overrun dropped", 0, flag);
    mce = 1'b1;
    far.send_frame(8'h77, 1'b0);
    check("bad stop", 0, flag);
    far.send_frame(8'h66, 1'b1);
    sfr_read(8'h99, v);
    check("good stop", 8'h66, v);
    release_flag;
    mce = 1'b0;
    far.send_frame(8'h81, 1'b0);
    sfr_read(8'h99, v);
    check("stop ignored", 8'h81, v);
    release_flag;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_reset;
    t_baud;
    t_tx;
    t_rx;
    test_done;
  end
  // watchdog well beyond the expected run of some 51k clocks
  initial begin
    #800000;
    n_errors++;
    test_done;
  end
endmodule
`default_nettype wire
